/* src/intr_pos_pkg.sv */
package intr_pos_pkg;

    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_DISTANCE = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CRUISE = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_RAMP = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_RELEASE = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_POLARITY = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_REF_COUNT = 8'h24;

    localparam logic [15:0] RST_ENABLE = 16'h0000;
    localparam logic [31:0] RST_DISTANCE = 32'h0000_2710;
    localparam logic [15:0] RST_CRUISE = 16'h00c8;
    localparam logic [15:0] RST_RAMP = 16'h000a;
    localparam logic [15:0] RST_RELEASE = 16'h0001;
    localparam logic [15:0] RST_POLARITY = 16'h0000;

    localparam logic [31:0] MAX_DISTANCE = 32'h4000_0000;
    localparam logic [15:0] MAX_CRUISE = 16'h1770;
    localparam logic [15:0] MAX_RAMP = 16'h03e8;
    localparam logic [15:0] MIN_TRIG_SPEED = 16'h000a;
    localparam logic [15:0] RAMP_REF_SPEED = 16'h03e8;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    localparam int IRQ_W = 3;
    localparam int IRQ_START = 0;
    localparam int IRQ_DONE = 1;
    localparam int IRQ_DROPPED = 2;

    typedef enum logic [2:0] {
        POL_FALL_A, POL_RISE_A, POL_RISE_B, POL_FALL_B, POL_BOTH
    } polarity_t;

    typedef struct packed {
        logic servo_on;
        logic position_mode;
        logic homing_busy;
        logic [15:0] speed_rpm;
        logic speed_dir_neg;
    } drive_state_t;

    typedef struct packed {
        logic active;
        logic dir_neg;
        logic [31:0] distance;
        logic [15:0] speed_rpm;
        logic [15:0] ramp_ms;
    } move_cmd_t;

endpackage

/* src/interrupt_positioning_control.sv */
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
// Notes on behaviour
// - triggers arriving during homing are ignored.
// - position mode plus servo-on: trigger aborts move, starts preset move, same direction.
// - during the move no position reference is accepted, nor another trigger.
// - reference counter accumulates only the interrupt displacement during the move.
// - references arriving during the move are dropped, never replayed.
// - on completion assert done and position-reached; done low while unfinished.
// - done output ignores servo-on and trigger polarity.
// - trigger valid if prior speed at least 10 rpm, or cruise and distance nonzero.
// - active block input prevents interrupt positioning.
// - moving average filter bypassed for the whole move.
// - enable 0 off, 1 on, default 0, written at stop, used after power-on.
// - distance 0 to 1073741824, default 10000, applies immediately.
// - cruise speed 0 to 6000 rpm, default 200, sets move speed.
// - ramp time 0 to 1000 ms, default 10, for 0 to 1000 rpm.
// - release setting 0 frees after done; 1 waits for release input.
// - trigger is edge-only; codes 0/3 fall, 1/2 rise, 4 both, others edge.
// - cruise 0 uses speed before trigger; nonzero uses the setting.
module interrupt_positioning_control
    import intr_pos_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire drive_state_t drive_state,
    input wire logic power_on_load,
    input wire logic intr_trigger_input,
    input wire logic intr_block_in,
    input wire logic intr_release_in,
    input wire logic ext_ref_valid,
    input wire logic [31:0] ext_ref_pulses,
    input wire logic move_finished_in,
    input wire logic deviation_ok_in,
    output move_cmd_t move_cmd,
    output logic abort_move_out,
    output logic ref_accept_out,
    output logic filter_bypass_out,
    output logic [31:0] input_reference_counter,
    output logic intr_move_done_out,
    output logic position_reached_out,
    output logic irq
);

    typedef enum logic [1:0] {ST_IDLE, ST_MOVING, ST_LOCKED} state_t;

    function automatic logic [31:0] clamp32(input logic [31:0] v, input logic [31:0] lim);
        clamp32 = (v > lim) ? lim : v;
    endfunction

    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lim);
        clamp16 = (v > lim) ? lim : v;
    endfunction

    logic [15:0] enable_cfg_reg;
    logic enable_live_reg;
    logic [31:0] distance_reg;
    logic [15:0] cruise_reg;
    logic [15:0] ramp_reg;
    logic [15:0] release_reg;
    logic [15:0] polarity_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    state_t state_reg;
    logic trig_prev_reg;
    logic done_reg;
    logic reached_reg;
    logic [31:0] ref_count_reg;

    logic aw_held_reg;
    logic w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;
    logic wr_hit;
    logic [31:0] rd_value;
    logic rd_hit;

    logic rise;
    logic fall;
    logic edge_seen;
    logic qualified;
    logic start;
    logic dropped;
    logic [IRQ_W-1:0] irq_events;

    // trigger edge detection; non-edge codes are treated as edge anyway
    always_comb begin
        rise = intr_trigger_input & ~trig_prev_reg;
        fall = ~intr_trigger_input & trig_prev_reg;
        case (polarity_reg[2:0])
            POL_FALL_A, POL_FALL_B: edge_seen = fall;
            POL_RISE_A, POL_RISE_B: edge_seen = rise;
            POL_BOTH: edge_seen = rise | fall;
            default: edge_seen = rise;
        endcase
    end

    // all qualifiers read in the same cycle as the edge
    always_comb begin
        qualified = enable_live_reg
            && drive_state.position_mode && drive_state.servo_on
            && !drive_state.homing_busy
            && !intr_block_in
            && ((drive_state.speed_rpm >= MIN_TRIG_SPEED)
                || (cruise_reg != 16'h0000 && distance_reg != 32'h0000_0000));
        start = edge_seen && qualified && (state_reg == ST_IDLE);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_prev_reg <= 1'b0;
        end else begin
            trig_prev_reg <= intr_trigger_input;
        end
    end

    // enable is latched only at power-on load, so run-time writes wait
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_live_reg <= 1'b0;
        end else if (power_on_load) begin
            enable_live_reg <= enable_cfg_reg[0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        state_reg <= ST_MOVING;
                    end
                end
                ST_MOVING: begin
                    if (move_finished_in) begin
                        state_reg <= (release_reg[0]) ? ST_LOCKED : ST_IDLE;
                    end
                end
                ST_LOCKED: begin
                    if (intr_release_in || !release_reg[0]) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // move command captured on start; distance, ramp and a nonzero cruise follow live settings
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            move_cmd <= '0;
        end else if (start) begin
            move_cmd.active <= 1'b1;
            move_cmd.dir_neg <= drive_state.speed_dir_neg;
            move_cmd.distance <= distance_reg;
            move_cmd.speed_rpm <= (cruise_reg == 16'h0000)
                ? drive_state.speed_rpm : cruise_reg;
            move_cmd.ramp_ms <= ramp_reg;
        end else if (state_reg == ST_MOVING && move_finished_in) begin
            move_cmd.active <= 1'b0;
        end else if (state_reg == ST_MOVING) begin
            move_cmd.distance <= distance_reg;
            if (cruise_reg != 16'h0000) begin
                move_cmd.speed_rpm <= cruise_reg;
            end
            move_cmd.ramp_ms <= ramp_reg;
        end
    end

    assign abort_move_out = start;
    assign ref_accept_out = (state_reg == ST_IDLE);
    assign filter_bypass_out = (state_reg == ST_MOVING);
    assign dropped = ext_ref_valid && (state_reg != ST_IDLE || start);

    // counter takes the interrupt distance once; refused references never add
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_count_reg <= 32'h0000_0000;
        end else if (start) begin
            ref_count_reg <= ref_count_reg + distance_reg;
        end else if (ext_ref_valid && state_reg == ST_IDLE) begin
            ref_count_reg <= ref_count_reg + ext_ref_pulses;
        end
    end
    assign input_reference_counter = ref_count_reg;

    // done is independent of servo-on and polarity on purpose
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_reg <= 1'b0;
            reached_reg <= 1'b0;
        end else begin
            if (start) begin
                done_reg <= 1'b0;
            end else if (state_reg == ST_MOVING && move_finished_in) begin
                done_reg <= 1'b1;
            end else if (state_reg == ST_IDLE && intr_release_in) begin
                done_reg <= 1'b0;
            end
            if (state_reg == ST_MOVING) begin
                reached_reg <= move_finished_in;
            end else begin
                reached_reg <= deviation_ok_in && drive_state.servo_on;
            end
        end
    end
    assign intr_move_done_out = done_reg;
    assign position_reached_out = reached_reg;

    // axi write path: address and data may come in either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        case (awaddr_reg)
            OFF_ENABLE, OFF_DISTANCE, OFF_CRUISE, OFF_RAMP, OFF_RELEASE,
            OFF_POLARITY, OFF_IRQ_STAT, OFF_IRQ_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // settings are full-word writes; distance clamps to its limit, cruise and ramp clamp their low 16 bits to the limit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_cfg_reg <= RST_ENABLE;
            distance_reg <= RST_DISTANCE;
            cruise_reg <= RST_CRUISE;
            ramp_reg <= RST_RAMP;
            release_reg <= RST_RELEASE;
            polarity_reg <= RST_POLARITY;
            irq_mask_reg <= '0;
        end else if (wr_fire) begin
            case (awaddr_reg)
                OFF_ENABLE: begin
                    if (state_reg == ST_IDLE && !drive_state.servo_on) begin
                        enable_cfg_reg <= {15'h0000, wdata_reg[0]};
                    end
                end
                OFF_DISTANCE: distance_reg <= clamp32(wdata_reg, MAX_DISTANCE);
                OFF_CRUISE: cruise_reg <= clamp16(wdata_reg[15:0], MAX_CRUISE);
                OFF_RAMP: ramp_reg <= clamp16(wdata_reg[15:0], MAX_RAMP);
                OFF_RELEASE: release_reg <= {15'h0000, wdata_reg[0]};
                OFF_POLARITY: polarity_reg <= wdata_reg[15:0];
                OFF_IRQ_MASK: irq_mask_reg <= wdata_reg[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // set wins over a same-cycle write-one clear
    assign irq_events = {dropped, (state_reg == ST_MOVING && move_finished_in), start};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= '0;
        end else if (wr_fire && awaddr_reg == OFF_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~wdata_reg[IRQ_W-1:0]) | irq_events;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_events;
        end
    end
    assign irq = |(irq_stat_reg & irq_mask_reg);

    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            OFF_ENABLE: rd_value = {16'h0000, enable_cfg_reg};
            OFF_DISTANCE: rd_value = distance_reg;
            OFF_CRUISE: rd_value = {16'h0000, cruise_reg};
            OFF_RAMP: rd_value = {16'h0000, ramp_reg};
            OFF_RELEASE: rd_value = {16'h0000, release_reg};
            OFF_POLARITY: rd_value = {16'h0000, polarity_reg};
            OFF_STATUS: rd_value = {27'h0, enable_live_reg, done_reg, reached_reg, state_reg};
            OFF_IRQ_STAT: rd_value = {{(32-IRQ_W){1'b0}}, irq_stat_reg};
            OFF_IRQ_MASK: rd_value = {{(32-IRQ_W){1'b0}}, irq_mask_reg};
            OFF_REF_COUNT: rd_value = ref_count_reg;
            default: begin
                rd_value = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    property p_homing_blocks;
        @(posedge aclk) disable iff (!aresetn)
        drive_state.homing_busy |-> !abort_move_out;
    endproperty
    a_homing_blocks: assert property (p_homing_blocks) else $error("start during homing");
    property p_start_moves;
        @(posedge aclk) disable iff (!aresetn)
        abort_move_out |=> filter_bypass_out && move_cmd.active;
    endproperty
    a_start_moves: assert property (p_start_moves) else $error("start did not move");
    property p_no_retrigger;
        @(posedge aclk) disable iff (!aresetn)
        filter_bypass_out |-> !abort_move_out && !ref_accept_out;
    endproperty
    a_no_retrigger: assert property (p_no_retrigger) else $error("accepted during move");
    property p_count_drop;
        @(posedge aclk) disable iff (!aresetn)
        (!ref_accept_out && !abort_move_out)
            |=> input_reference_counter == $past(input_reference_counter);
    endproperty
    a_count_drop: assert property (p_count_drop) else $error("counter moved");
    property p_done;
        @(posedge aclk) disable iff (!aresetn)
        (filter_bypass_out && move_finished_in) |=> intr_move_done_out && position_reached_out;
    endproperty
    a_done: assert property (p_done) else $error("done not shown");
    property p_done_low;
        @(posedge aclk) disable iff (!aresetn)
        abort_move_out |=> !intr_move_done_out;
    endproperty
    a_done_low: assert property (p_done_low) else $error("done high while moving");
    property p_block;
        @(posedge aclk) disable iff (!aresetn)
        intr_block_in |-> !abort_move_out;
    endproperty
    a_block: assert property (p_block) else $error("start while blocked");
    property p_lock;
        @(posedge aclk) disable iff (!aresetn)
        (filter_bypass_out && move_finished_in && release_reg[0])
            ##1 (!intr_release_in)[*2] |-> !ref_accept_out;
    endproperty
    a_lock: assert property (p_lock) else $error("lock released early");

    c_start: cover property (@(posedge aclk) disable iff (!aresetn) abort_move_out);
    c_done: cover property (@(posedge aclk) disable iff (!aresetn) $rose(intr_move_done_out));
    c_drop: cover property (@(posedge aclk) disable iff (!aresetn) irq_events[IRQ_DROPPED]);

endmodule // interrupt_positioning_control

/* dv/profile_gen_model.sv */
`timescale 1ns/100ps
module profile_gen_model
    import intr_pos_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire move_cmd_t move_cmd,
    input wire logic [7:0] delay,
    output logic move_finished,
    output logic dev_ok
);
    logic [7:0] cnt_reg;
    // one finish pulse per move; a long delay models a slow axis
    always_ff @(posedge aclk) begin
        if (!aresetn || !move_cmd.active) begin
            cnt_reg <= 8'h00;
            move_finished <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            move_finished <= (cnt_reg == delay);
        end
    end
    assign dev_ok = !move_cmd.active;
endmodule // profile_gen_model

/* dv/testbench.sv */
`timescale 1ns/100ps
module testbench
    import intr_pos_pkg::*;
;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr, delay;
    logic [31:0] wdata, rdata, pulses, cnt, rd;
    logic [1:0] bresp, rresp, rs;
    logic pol, trig, blk, rel, ref_v, fin, dev_ok, abort, acc, byp, done, reached, irq, x1, x2;
    drive_state_t ds;
    move_cmd_t mc;
    int err_count, comparisons, n_abort, b;
    localparam logic [7:0] OFFS [5] = '{OFF_ENABLE, OFF_DISTANCE, OFF_CRUISE, OFF_RAMP, OFF_RELEASE};
    localparam logic [31:0] RSTS [5] = '{32'(RST_ENABLE), RST_DISTANCE, 32'(RST_CRUISE),
        32'(RST_RAMP), 32'(RST_RELEASE)};

    interrupt_positioning_control uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .drive_state(ds),
        .power_on_load(pol), .intr_trigger_input(trig), .intr_block_in(blk),
        .intr_release_in(rel), .ext_ref_valid(ref_v), .ext_ref_pulses(pulses),
        .move_finished_in(fin), .deviation_ok_in(dev_ok), .move_cmd(mc), .abort_move_out(abort),
        .ref_accept_out(acc), .filter_bypass_out(byp), .input_reference_counter(cnt),
        .intr_move_done_out(done), .position_reached_out(reached), .irq(irq));

    profile_gen_model partner (.aclk(aclk), .aresetn(aresetn), .move_cmd(mc), .delay(delay),
        .move_finished(fin), .dev_ok(dev_ok));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // abort is a one-cycle pulse, so it is counted rather than sampled late
    always @(posedge aclk) if (aresetn === 1'b1 && abort === 1'b1) n_abort++;

    task end_of_test();
        begin
            $display("mismatches %0d comparisons %0d", err_count, comparisons);
            if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            comparisons++;
            if (seen !== exp) begin
                err_count++;
                $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task axi_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        begin
            n = 0;
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            do begin
                @(posedge aclk);
                n++;
                if (awvalid && awready) awvalid <= 1'b0;
                if (wvalid && wready) wvalid <= 1'b0;
            end while (bvalid !== 1'b1 && n < 50);
            check({30'h0, bresp}, {30'h0, RESP_OKAY});
            if (n >= 50) err_count++;
        end
    endtask

    task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        begin
            n = 0;
            araddr <= a;
            arvalid <= 1'b1;
            do begin
                @(posedge aclk);
                n++;
                if (arvalid && arready) arvalid <= 1'b0;
            end while (rvalid !== 1'b1 && n < 50);
            d = rdata;
            r = rresp;
            if (n >= 50) err_count++;
        end
    endtask

    task edge_to(input logic v);
        begin
            trig <= v;
            cyc(4);
        end
    endtask

    task ext_ref(input logic [31:0] p);
        begin
            ref_v <= 1'b1;
            pulses <= p;
            @(posedge aclk);
            ref_v <= 1'b0;
            cyc(2);
        end
    endtask

    task wait_idle();
        int n;
        begin
            n = 0;
            while (mc.active !== 1'b0 && n < 200) begin
                @(posedge aclk);
                n++;
            end
            if (n >= 200) err_count++;
            cyc(2);
        end
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        end_of_test();
    end

    initial begin
        {awvalid, wvalid, arvalid, pol, trig, blk, rel, ref_v} = '0;
        {awaddr, araddr, wdata, pulses} = '0;
        bready = 1'b1;
        rready = 1'b1;
        ds = '0;
        delay = 8'd40;
        aresetn = 1'b0;
        cyc(6);
        aresetn <= 1'b1;
        cyc(1);
        for (int i = 0; i < 5; i++) begin
            axi_read(OFFS[i], rd, rs);
            check(rd, RSTS[i]);
        end
        axi_read(8'hfc, rd, rs);
        check({30'h0, rs}, {30'h0, RESP_SLVERR});
        ds.position_mode <= 1'b1;
        ds.speed_rpm <= 16'h0064;
        ds.speed_dir_neg <= 1'b1;
        axi_write(OFF_ENABLE, 32'h1);
        axi_write(OFF_POLARITY, 32'h1);
        ds.servo_on <= 1'b1;
        edge_to(1'b1);
        edge_to(1'b0);
        check(32'(n_abort), 32'h0);
        ds.servo_on <= 1'b0;
        cyc(1);
        pol <= 1'b1;
        cyc(1);
        pol <= 1'b0;
        ds.servo_on <= 1'b1;
        axi_write(OFF_DISTANCE, 32'h1234);
        edge_to(1'b1);
        check(32'(n_abort), 32'h1);
        check({mc.active, mc.dir_neg}, 32'h3);
        check(mc.distance, 32'h1234);
        check(32'(mc.speed_rpm), 32'h00c8);
        check({byp, acc, done}, 32'h4);
        check(cnt, 32'h1234);
        ext_ref(32'h5);
        check(32'(mc.ramp_ms), 32'h000a);
        axi_write(OFF_DISTANCE, 32'hffff_ffff);
        cyc(1);
        check(mc.distance, 32'h4000_0000);
        edge_to(1'b0);
        edge_to(1'b1);
        check(cnt, 32'h1234);
        check(32'(n_abort), 32'h1);
        wait_idle();
        check({done, reached}, 32'h3);
        ds.servo_on <= 1'b0;
        cyc(2);
        check(32'(done), 32'h1);
        ds.servo_on <= 1'b1;
        axi_read(OFF_STATUS, rd, rs);
        check(32'(rd[1:0]), 32'h2);
        ext_ref(32'h5);
        check(cnt, 32'h1234);
        axi_read(OFF_IRQ_STAT, rd, rs);
        check(32'(rd[2:0]), 32'h7);
        axi_write(OFF_IRQ_MASK, 32'h7);
        x1 = irq;
        axi_write(OFF_IRQ_MASK, 32'h0);
        x2 = irq;
        check(32'(x1 ^ x2), 32'h1);
        axi_write(OFF_IRQ_STAT, 32'h7);
        axi_read(OFF_IRQ_STAT, rd, rs);
        check({rd[2:0], irq}, 32'h0);
        rel <= 1'b1;
        cyc(2);
        rel <= 1'b0;
        axi_read(OFF_STATUS, rd, rs);
        check(32'(rd[1:0]), 32'h0);
        ext_ref(32'h5);
        check(cnt, 32'h1239);
        // release setting 0 lets each later move fall straight back to idle
        axi_write(OFF_RELEASE, 32'h0);
        delay <= 8'd8;
        for (int i = 0; i < 4; i++) begin
            ds.homing_busy <= (i == 0);
            blk <= (i == 1);
            ds.position_mode <= (i != 2);
            ds.speed_rpm <= (i == 3) ? 16'h0005 : 16'h0064;
            if (i == 3) axi_write(OFF_CRUISE, 32'h0);
            edge_to(1'b0);
            edge_to(1'b1);
            check(32'(n_abort), 32'h1);
        end
        {ds.homing_busy, blk} <= 2'b00;
        ds.position_mode <= 1'b1;
        ds.speed_rpm <= 16'h0032;
        edge_to(1'b0);
        edge_to(1'b1);
        check(32'(mc.speed_rpm), 32'h0032);
        wait_idle();
        axi_read(OFF_STATUS, rd, rs);
        check(32'(rd[1:0]), 32'h0);
        ds.speed_rpm <= 16'h0005;
        axi_write(OFF_CRUISE, 32'h012c);
        edge_to(1'b0);
        edge_to(1'b1);
        check(32'(n_abort), 32'h3);
        check(32'(mc.speed_rpm), 32'h012c);
        wait_idle();
        for (int p = 0; p < 5; p++) begin
            axi_write(OFF_POLARITY, 32'(p));
            b = n_abort;
            edge_to(1'b0);
            cyc(12);
            check(32'(n_abort - b), 32'(p == 0 || p == 3 || p == 4));
            b = n_abort;
            edge_to(1'b1);
            cyc(12);
            check(32'(n_abort - b), 32'(p == 1 || p == 2 || p == 4));
        end
        end_of_test();
    end
endmodule // testbench
